//--- pstb_bank.sv
// Telemetry and status read-back bank behind the management link
// Behaviour
// - Any vendor status bit sets summary bit
// - Writing one clears that vendor status bit, except the fault-log bit
// - Fault-log bit clears only by erase command
// - Any vendor fault bit drives alert
// - Pin word bits 15..8 as documented
// - Pin word bits 7..0 run/GPIO states
// - Pin word bits read one when true
// - Common byte bits, read-only
// - Info bit 5 reports correction status
// - Correction bit refreshed on restore/reset/POR/bulk
// - Answer voltage and current telemetry codes
// - Answer temperature, duty, frequency, power codes
// - Peaks hold maxima since peak clear
// - ADC select byte, read/write, resets zero
// - Short-loop flags latch Vout/Iout conversions in short-loop mode until write-one clear
// - External temperature drives compensation only
// - Vout L16, others L11 format
// - Total input current sums channels
// - Channel current is offset plus iout*duty
// - Output current from sense, gain, temperature
// - Log bit 3, paged GPIO bit 0
// - Summary bit sits at bit 12
`timescale 1ns/1ps
`default_nettype none
module pstb_bank import pstb_pkg::*; #(
    parameter int EXP_VIN = -4,
    parameter int EXP_IOUT = -3,
    parameter int EXP_TEMP = -2
) (
    input wire logic clock,
    input wire logic rst_b,
    input wire logic linkClock,
    input wire logic linkReq,
    input wire logic linkWrite,
    input wire logic linkPage,
    input wire logic [7:0] linkCode,
    input wire logic [15:0] linkData,
    output logic linkBusy,
    output logic linkDone,
    output logic [15:0] linkRdata,
    input wire logic [7:1] vendorEvent,
    input wire logic [1:0] gpioExtLow,
    input wire logic bulkReadDone,
    input wire logic eccCorrected,
    input wire logic adcValid,
    input wire logic [7:0] adcSel,
    input wire logic [15:0] adcValue,
    input wire logic [1:0][9:0] dutyFrac,
    input wire logic [10:0] freqMant,
    input wire logic [1:0][10:0] poutMant,
    input wire logic [4:0] voutExp,
    input wire logic [1:0][10:0] inputCurrentOffset,
    input wire logic [1:0][10:0] currentGain,
    input wire logic [1:0][10:0] currentGainTempco,
    input wire logic [1:0][10:0] extTempGain,
    input wire logic [1:0][10:0] extTempOffset,
    input wire logic coreSupplyOv,
    input wire logic coreSupplyUv,
    input wire logic adcInvalid,
    input wire logic syncDisabled,
    input wire logic [1:0] powerOk,
    input wire logic [1:0] driveEnableLow,
    input wire logic [1:0] enablePin,
    input wire logic [1:0] driveFaultLow,
    input wire logic [1:0] faultPin,
    input wire logic busy,
    input wire logic calcPending,
    input wire logic inTransition,
    input wire logic nvmInit,
    input wire logic sharedTimebaseTimeout,
    input wire logic wpPin,
    output logic alertOut,
    output logic alertOe,
    output logic [1:0] vendorSummary,
    output logic [7:0] adcSelect,
    output logic [7:0] cmlFlags
);
    // Link-domain reset and handshake state
    logic lrS1, lrS2;
    pstb_link_t lkState;
    logic reqTgl, ackS1, ackS2, ackSeen;
    logic lkWr, lkPg;
    logic [7:0] lkCode;
    logic [15:0] lkData;
    // Core-side crossing flops
    logic rqS1, rqS2, rqSeen, ackTgl;
    logic [15:0] rdHold;
    // Status state
    logic [7:1] vShared;
    logic [1:0] gpioExt;
    logic [7:6] cml;
    logic [3:0] srr;
    logic eccOk, porPend;
    // Pin synchronisers (enable, fault, wp)
    logic [4:0] pinS1, pinS2;
    // Telemetry mantissas and peaks
    logic signed [10:0] vin, vinPk, tdie, tdiePk;
    logic [1:0][15:0] vout, voutPk;
    logic signed [1:0][10:0] iout, ioutPk, text, textPk, sense;

    // Link reset: two flops bring rst_b into the link clock
    always_ff @(posedge linkClock) begin
        lrS1 <= rst_b;
        lrS2 <= lrS1;
    end

    // Acknowledge toggle crosses back to the link side
    always_ff @(posedge linkClock) begin
        ackS1 <= ackTgl;
        ackS2 <= ackS1;
    end

    wire lkTake = linkReq && (lkState == LK_IDLE);
    wire lkAck = (lkState == LK_WAIT) && (ackS2 != ackSeen);

    // Link request capture; bundled data stays frozen while waiting
    always_ff @(posedge linkClock) begin
        if (!lrS2) begin
            lkState <= LK_IDLE;
            reqTgl <= 1'b0;
            ackSeen <= 1'b0;
            linkDone <= 1'b0;
            linkRdata <= 16'h0000;
            lkWr <= 1'b0;
            lkPg <= 1'b0;
            lkCode <= 8'h00;
            lkData <= 16'h0000;
        end else begin
            linkDone <= lkAck;
            case (lkState)
                LK_IDLE: begin
                    if (lkTake) begin
                        lkWr <= linkWrite;
                        lkPg <= linkPage;
                        lkCode <= linkCode;
                        lkData <= linkData;
                        reqTgl <= ~reqTgl;
                        lkState <= LK_WAIT;
                    end
                end
                LK_WAIT: begin
                    // Core holds rdHold until the next request
                    if (lkAck) begin
                        ackSeen <= ackS2;
                        linkRdata <= rdHold;
                        lkState <= LK_IDLE;
                    end
                end
                default: lkState <= LK_IDLE;
            endcase
        end
    end
    assign linkBusy = (lkState != LK_IDLE);

    // Request toggle into core clock
    always_ff @(posedge clock) begin
        rqS1 <= reqTgl;
        rqS2 <= rqS1;
    end

    // Pins from outside pass two flops before use
    always_ff @(posedge clock) begin
        pinS1 <= {wpPin, faultPin, enablePin};
        pinS2 <= pinS1;
    end

    // Decoded core access
    wire acc = (rqS2 != rqSeen);
    wire wr = acc && lkWr;
    wire rd = acc && !lkWr;
    wire pg = lkPg;
    wire [7:0] wb = lkData[7:0];
    wire isRw = (lkCode == C_ADCSEL) || (lkCode == C_SRR) || (lkCode == C_VSTAT)
        || (lkCode == C_CML);
    wire isSend = (lkCode == C_CLRALL) || (lkCode == C_RESTORE) || (lkCode == C_LOGERASE)
        || (lkCode == C_PEAKRST) || (lkCode == C_DEVRESET);
    wire roWrite = wr && !isRw && !isSend;
    wire wStat = wr && (lkCode == C_VSTAT);
    wire clrAll = wr && (lkCode == C_CLRALL);
    wire logErase = wr && (lkCode == C_LOGERASE);
    wire peakRst = wr && (lkCode == C_PEAKRST);
    wire eccEvt = porPend || bulkReadDone
        || (wr && ((lkCode == C_RESTORE) || (lkCode == C_DEVRESET)));
    wire selBad = (wb == 8'h02) || (wb == 8'h03) || (wb == 8'h07) || (wb == 8'h0b)
        || (wb > S_SRR);

    // Vendor byte per page: shared bits 7..1, paged GPIO bit 0
    wire [7:0] vb0 = {vShared, gpioExt[0]};
    wire [7:0] vb1 = {vShared, gpioExt[1]};
    wire [7:0] vbSel = pg ? vb1 : vb0;
    // Clear masks; fault-log bit is immune to write-one-to-clear
    wire [7:1] wClr = wStat ? (wb[7:1] & ~(7'h01 << (B_LOG - 1))) : 7'h00;
    wire [7:1] aClr = clrAll ? ~(7'h01 << (B_LOG - 1)) : 7'h00;
    wire [7:1] eClr = logErase ? (7'h01 << (B_LOG - 1)) : 7'h00;

    // Vendor status: events win over any clear in the same cycle
    always_ff @(posedge clock) begin
        if (!rst_b) begin
            vShared <= 7'h00;
            gpioExt <= 2'b00;
        end else begin
            vShared <= vendorEvent | (vShared & ~(wClr | aClr | eClr));
            gpioExt[0] <= gpioExtLow[0] | (gpioExt[0] & ~clrAll
                & ~(wStat && !pg && wb[B_GPIOEXT]));
            gpioExt[1] <= gpioExtLow[1] | (gpioExt[1] & ~clrAll
                & ~(wStat && pg && wb[B_GPIOEXT]));
        end
    end
    assign vendorSummary = {|vb1, |vb0};
    // Open-drain alert pulled while any fault stands
    assign alertOut = 1'b0;
    assign alertOe = |vb0 || |vb1;

    // Command errors: writes to read-only words and bad select values
    always_ff @(posedge clock) begin
        if (!rst_b) begin
            cml <= 2'b00;
        end else begin
            cml[B_CMLCMD] <= roWrite
                | (cml[B_CMLCMD] & ~clrAll & ~(wr && (lkCode == C_CML) && wb[B_CMLCMD]));
            cml[B_CMLDATA] <= (wr && (lkCode == C_ADCSEL) && selBad)
                | (cml[B_CMLDATA] & ~clrAll & ~(wr && (lkCode == C_CML) && wb[B_CMLDATA]));
        end
    end
    assign cmlFlags = {cml, 6'h00};

    // ADC select: reserved values fall back to die temperature
    always_ff @(posedge clock) begin
        if (!rst_b) begin
            adcSelect <= ADCSEL_RST;
        end else if (wr && (lkCode == C_ADCSEL)) begin
            adcSelect <= selBad ? S_TDIE : wb;
        end
    end

    // Short loop flags: set on conversion, write one clears, set wins
    wire srrOn = (adcSelect == S_SRR);
    wire [3:0] srrSet = (adcValid && srrOn) ? {adcSel == S_IOUT1, adcSel == S_VOUT1,
        adcSel == S_IOUT0, adcSel == S_VOUT0} : 4'h0;
    always_ff @(posedge clock) begin
        if (!rst_b) begin
            srr <= 4'h0;
        end else begin
            srr <= srrSet | (srr & ~((wr && (lkCode == C_SRR)) ? wb[3:0] : 4'h0));
        end
    end

    // Correction status; power-on refresh happens after reset release
    always_ff @(posedge clock) begin
        if (!rst_b) begin
            porPend <= 1'b1;
            eccOk <= 1'b1;
        end else begin
            porPend <= 1'b0;
            if (eccEvt) begin
                eccOk <= ~eccCorrected;
            end
        end
    end

    // Sample decode; die temperature feeds no other word
    wire sVin = adcValid && (adcSel == S_VIN);
    wire sTdie = adcValid && (adcSel == S_TDIE);
    wire [1:0] sVout = {2{adcValid}} & {adcSel == S_VOUT1, adcSel == S_VOUT0};
    wire [1:0] sIout = {2{adcValid}} & {adcSel == S_IOUT1, adcSel == S_IOUT0};
    wire [1:0] sText = {2{adcValid}} & {adcSel == S_TEXT1, adcSel == S_TEXT0};
    wire signed [10:0] aM = adcValue[10:0];

    // Current arithmetic per channel
    logic signed [1:0][10:0] ioutNew, iinCh;
    always_comb begin
        for (int c = 0; c < 2; c++) begin
            logic signed [22:0] tCal, gEff, prod, ip;
            tCal = 23'((32'(text[c]) * 32'(extTempGain[c])) >>> DUTY_SH)
                + 23'(extTempOffset[c]);
            // Gain follows the external temperature only
            gEff = 23'(currentGain[c])
                + 23'((32'(currentGainTempco[c]) * 32'(tCal)) >>> TC_SH);
            prod = 23'((32'(sense[c]) * 32'(gEff)) >>> GAIN_SH);
            // Average held reading with the scaled sense sample of the previous conversion
            ioutNew[c] = 11'((23'(iout[c]) + prod) >>> 1);
            ip = 23'((32'(iout[c]) * 32'({1'b0, dutyFrac[c]})) >>> DUTY_SH);
            iinCh[c] = 11'(23'(inputCurrentOffset[c]) + ip);
        end
    end
    // Total carries one more exponent step so the sum cannot overflow
    wire signed [11:0] iinSum = 12'(iinCh[0]) + 12'(iinCh[1]);
    wire [15:0] iinTotal = {5'(EXP_IOUT + 1), iinSum[11:1]};

    // Channel telemetry and peak hold
    always_ff @(posedge clock) begin
        if (!rst_b) begin
            vout <= '0;
            voutPk <= '0;
            iout <= '0;
            ioutPk <= {2{11'h400}};
            text <= '0;
            textPk <= {2{11'h400}};
            sense <= '0;
        end else begin
            for (int c = 0; c < 2; c++) begin
                if (sVout[c]) vout[c] <= adcValue;
                if (sText[c]) text[c] <= aM;
                if (sIout[c]) begin
                    sense[c] <= aM;
                    iout[c] <= ioutNew[c];
                end
                // Peak clear restarts from the floor of each format
                if (peakRst) begin
                    voutPk[c] <= 16'h0000;
                    ioutPk[c] <= 11'h400;
                    textPk[c] <= 11'h400;
                end else begin
                    if (sVout[c] && adcValue > voutPk[c]) voutPk[c] <= adcValue;
                    // Elements of a packed array are unsigned: compare as signed mantissas
                    if (sIout[c] && $signed(ioutNew[c]) > $signed(ioutPk[c])) begin
                        ioutPk[c] <= ioutNew[c];
                    end
                    if (sText[c] && aM > $signed(textPk[c])) textPk[c] <= aM;
                end
            end
        end
    end

    // Unpaged telemetry and peak hold
    always_ff @(posedge clock) begin
        if (!rst_b) begin
            vin <= '0;
            vinPk <= 11'h400;
            tdie <= '0;
            tdiePk <= 11'h400;
        end else begin
            if (sVin) vin <= aM;
            if (sTdie) tdie <= aM;
            if (peakRst) begin
                vinPk <= 11'h400;
                tdiePk <= 11'h400;
            end else begin
                if (sVin && aM > vinPk) vinPk <= aM;
                if (sTdie && aM > tdiePk) tdiePk <= aM;
            end
        end
    end

    // Read words: pin state, common byte, info word
    wire [15:0] pinWord = {coreSupplyOv, coreSupplyUv, 2'b00, adcInvalid, syncDisabled,
        powerOk,
        driveEnableLow, pinS2[1:0], driveFaultLow, pinS2[3:2]};
    wire [7:0] commonByte = {~alertOe, ~busy, ~calcPending, ~inTransition, nvmInit,
        1'b0, sharedTimebaseTimeout, pinS2[4]};
    wire [15:0] infoWord = 16'(eccOk) << B_ECC;
    wire [15:0] statWordHi = 16'(vendorSummary[pg]) << B_SUMMARY;
    // L11 packing with a fixed exponent; output voltage stays L16
    wire [4:0] eI = 5'(EXP_IOUT);
    wire [4:0] eT = 5'(EXP_TEMP);
    wire [4:0] eV = 5'(EXP_VIN);
    wire [15:0] rdMux =
        (lkCode == C_VIN) ? {eV, vin} :
        (lkCode == C_IIN) ? iinTotal :
        (lkCode == C_VOUT) ? vout[pg] :
        (lkCode == C_IOUT) ? {eI, iout[pg]} :
        (lkCode == C_IINCH) ? {eI, iinCh[pg]} :
        (lkCode == C_TEXT) ? {eT, text[pg]} :
        (lkCode == C_TDIE) ? {eT, tdie} :
        (lkCode == C_DUTY) ? {5'h00, 1'b0, dutyFrac[pg]} :
        (lkCode == C_FREQ) ? {5'h00, freqMant} :
        (lkCode == C_POUT) ? {5'h00, poutMant[pg]} :
        (lkCode == C_VOPK) ? voutPk[pg] :
        (lkCode == C_VIPK) ? {eV, vinPk} :
        (lkCode == C_TEPK) ? {eT, textPk[pg]} :
        (lkCode == C_TDPK) ? {eT, tdiePk} :
        (lkCode == C_IOPK) ? {eI, ioutPk[pg]} :
        (lkCode == C_ADCSEL) ? {8'h00, adcSelect} :
        (lkCode == C_SRR) ? {12'h000, srr} :
        (lkCode == C_VSTAT) ? {statWordHi[15:8], vbSel} :
        (lkCode == C_CML) ? {8'h00, cmlFlags} :
        (lkCode == C_PINS) ? pinWord :
        (lkCode == C_COMMON) ? {8'h00, commonByte} :
        (lkCode == C_INFO) ? infoWord : 16'h0000;

    // Answer capture and acknowledge toggle
    always_ff @(posedge clock) begin
        if (!rst_b) begin
            rqSeen <= 1'b0;
            ackTgl <= 1'b0;
            rdHold <= 16'h0000;
        end else if (acc) begin
            rqSeen <= rqS2;
            ackTgl <= ~ackTgl;
            rdHold <= rd ? rdMux : 16'h0000;
        end
    end

    // Checks on the core domain; one cover on the link clock
    a_summary_set: assert property (@(posedge clock) disable iff (!rst_b)
        |vendorEvent |=> vendorSummary == 2'b11) else $error("summary not set");
    a_w1c_clear: assert property (@(posedge clock) disable iff (!rst_b)
        wStat && wb[7] && !vendorEvent[7] |=> !vShared[7]) else $error("w1c failed");
    a_log_kept: assert property (@(posedge clock) disable iff (!rst_b)
        vShared[B_LOG] && !logErase |=> vShared[B_LOG]) else $error("log bit lost");
    a_alert_drive: assert property (@(posedge clock) disable iff (!rst_b)
        $rose(|vShared) |-> alertOe && !commonByte[7]) else $error("alert not driven");
    a_ro_reject: assert property (@(posedge clock) disable iff (!rst_b)
        roWrite |=> cml[B_CMLCMD] && $stable(adcSelect)) else $error("ro write taken");
    a_sel_reset: assert property (@(posedge clock)
        !rst_b |=> adcSelect == 8'h00) else $error("select not reset");
    a_ecc_refresh: assert property (@(posedge clock) disable iff (!rst_b)
        eccEvt |=> eccOk == !$past(eccCorrected)) else $error("ecc not refreshed");
    a_srr_flag: assert property (@(posedge clock) disable iff (!rst_b)
        adcValid && srrOn && adcSel == S_VOUT0 |=> srr[0]) else $error("flag not set");
    a_peak_clear: assert property (@(posedge clock) disable iff (!rst_b)
        peakRst ##1 !peakRst && !sVin |=> vinPk == 11'h400) else $error("peak not cleared");
    c_read_done: cover property (@(posedge linkClock) disable iff (!lrS2) lkAck && !lkWr);
    c_srr_mode: cover property (@(posedge clock) disable iff (!rst_b) srrOn && adcValid);
    c_log_erase: cover property (@(posedge clock) disable iff (!rst_b)
        vShared[B_LOG] ##1 logErase);
endmodule
`default_nettype wire

//--- pstb_pkg.sv
// Package: command codes, field positions and constants of the telemetry bank
package pstb_pkg;
    // Command codes of the read-back bank
    localparam logic [7:0] C_VIN = 8'h88;
    localparam logic [7:0] C_IIN = 8'h89;
    localparam logic [7:0] C_VOUT = 8'h8b;
    localparam logic [7:0] C_IOUT = 8'h8c;
    localparam logic [7:0] C_TEXT = 8'h8d;
    localparam logic [7:0] C_TDIE = 8'h8e;
    localparam logic [7:0] C_DUTY = 8'h94;
    localparam logic [7:0] C_FREQ = 8'h95;
    localparam logic [7:0] C_POUT = 8'h96;
    localparam logic [7:0] C_IOPK = 8'hd7;
    localparam logic [7:0] C_ADCSEL = 8'hd8;
    localparam logic [7:0] C_SRR = 8'hda;
    localparam logic [7:0] C_VOPK = 8'hdd;
    localparam logic [7:0] C_VIPK = 8'hde;
    localparam logic [7:0] C_TEPK = 8'hdf;
    localparam logic [7:0] C_IINCH = 8'hed;
    localparam logic [7:0] C_TDPK = 8'hf4;
    // Status, pin, info and command codes
    localparam logic [7:0] C_VSTAT = 8'h80;
    localparam logic [7:0] C_CML = 8'h7e;
    localparam logic [7:0] C_CLRALL = 8'h03;
    localparam logic [7:0] C_RESTORE = 8'h16;
    localparam logic [7:0] C_PINS = 8'he5;
    localparam logic [7:0] C_COMMON = 8'hef;
    localparam logic [7:0] C_INFO = 8'hb6;
    localparam logic [7:0] C_LOGERASE = 8'hec;
    localparam logic [7:0] C_PEAKRST = 8'he3;
    localparam logic [7:0] C_DEVRESET = 8'hfd;
    // Field positions
    localparam int B_LOG = 3;
    localparam int B_GPIOEXT = 0;
    localparam int B_SUMMARY = 12;
    localparam int B_ECC = 5;
    localparam int B_CMLCMD = 7;
    localparam int B_CMLDATA = 6;
    // ADC select values
    localparam logic [7:0] S_VIN = 8'h01;
    localparam logic [7:0] S_TDIE = 8'h04;
    localparam logic [7:0] S_VOUT0 = 8'h05;
    localparam logic [7:0] S_IOUT0 = 8'h06;
    localparam logic [7:0] S_TEXT0 = 8'h08;
    localparam logic [7:0] S_VOUT1 = 8'h09;
    localparam logic [7:0] S_IOUT1 = 8'h0a;
    localparam logic [7:0] S_TEXT1 = 8'h0c;
    localparam logic [7:0] S_SRR = 8'h0d;
    localparam logic [7:0] ADCSEL_RST = 8'h00;
    // Scaling of duty (1/1024) and gain (1/256)
    localparam int DUTY_SH = 10;
    localparam int GAIN_SH = 8;
    localparam int TC_SH = 12;
    // Link handshake states
    typedef enum logic {LK_IDLE, LK_WAIT} pstb_link_t;
endpackage

//--- pstb_host_model.sv
// Host-side model of the management link master
`timescale 1ns/1ps
`default_nettype none
module pstb_host_model (
    input wire logic linkClock,
    input wire logic linkBusy,
    input wire logic linkDone,
    input wire logic [15:0] linkRdata,
    output logic linkReq,
    output logic linkWrite,
    output logic linkPage,
    output logic [7:0] linkCode,
    output logic [15:0] linkData
);
    // Idle host: no request, lines parked
    initial begin
        linkReq = 1'b0;
        {linkWrite, linkPage, linkCode, linkData} = '0;
    end
    // One transfer at a time; gap models a slow host
    task automatic xfer(input logic wr, input logic pg, input logic [7:0] code,
                        input logic [15:0] data, input int gap, output logic [15:0] rdata);
        int n;
        repeat (gap + 1) @(posedge linkClock);
        linkReq <= 1'b1;
        linkWrite <= wr;
        linkPage <= pg;
        linkCode <= code;
        linkData <= data;
        n = 0;
        // Hold the request until an edge sees the device idle
        do begin
            @(posedge linkClock);
            n++;
        end while (linkBusy !== 1'b0 && n < 200);
        linkReq <= 1'b0;
        // Released lines must not keep the last value
        linkCode <= ~code;
        linkData <= ~data;
        do begin
            @(posedge linkClock);
            n++;
        end while (linkDone !== 1'b1 && n < 400);
        // A lost answer comes back unknown and fails the compare
        rdata = (n < 400) ? linkRdata : 16'hxxxx;
    endtask
endmodule
`default_nettype wire

//--- tb_top.sv
// Self-checking bench of the telemetry and status bank
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    import pstb_pkg::*;
    logic clock = 1'b0, linkClock = 1'b0, rst_b = 1'b0;
    logic linkReq, linkWrite, linkPage, linkBusy, linkDone;
    logic [7:0] linkCode, adcSel, adcSelect, cmlFlags;
    logic [15:0] linkData, linkRdata, adcValue;
    logic [7:1] vendorEvent;
    logic [1:0] gpioExtLow, powerOk, driveEnableLow, enablePin, driveFaultLow, faultPin;
    logic [1:0] vendorSummary;
    logic bulkReadDone, eccCorrected, adcValid, coreSupplyOv, coreSupplyUv, adcInvalid;
    logic syncDisabled, busy, calcPending, inTransition, nvmInit, sharedTimebaseTimeout;
    logic wpPin, alertOut, alertOe;
    logic [1:0][9:0] dutyFrac;
    logic [10:0] freqMant;
    logic [4:0] voutExp;
    logic [1:0][10:0] poutMant, inputCurrentOffset, currentGain, currentGainTempco;
    logic [1:0][10:0] extTempGain, extTempOffset;
    int n_fail = 0, tests_run = 0;
    // Core clock 50 ns; link clock 6 ns with an unrelated phase
    always #25 clock = ~clock;
    initial #1.3 forever #3 linkClock = ~linkClock;
    pstb_bank dut_u (.clock, .rst_b, .linkClock, .linkReq, .linkWrite, .linkPage, .linkCode,
        .linkData, .linkBusy, .linkDone, .linkRdata, .vendorEvent, .gpioExtLow, .bulkReadDone,
        .eccCorrected, .adcValid, .adcSel, .adcValue, .dutyFrac, .freqMant, .poutMant,
        .voutExp, .inputCurrentOffset, .currentGain, .currentGainTempco, .extTempGain,
        .extTempOffset, .coreSupplyOv, .coreSupplyUv, .adcInvalid, .syncDisabled, .powerOk,
        .driveEnableLow, .enablePin, .driveFaultLow, .faultPin, .busy, .calcPending,
        .inTransition, .nvmInit, .sharedTimebaseTimeout, .wpPin, .alertOut, .alertOe,
        .vendorSummary, .adcSelect, .cmlFlags);
    pstb_host_model host_u (.linkClock, .linkBusy, .linkDone, .linkRdata, .linkReq,
        .linkWrite, .linkPage, .linkCode, .linkData);
    // Compare and count
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        tests_run++;
        if (got !== exp) begin
            n_fail++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic rd(input logic pg, input logic [7:0] code, input logic [15:0] exp);
        logic [15:0] r;
        host_u.xfer(1'b0, pg, code, 16'h0000, 0, r);
        chk(r, exp);
    endtask
    // Writes use a slow host spacing
    task automatic wr(input logic pg, input logic [7:0] code, input logic [15:0] d);
        logic [15:0] r;
        host_u.xfer(1'b1, pg, code, d, 4, r);
    endtask
    task automatic core(input int n);
        repeat (n) @(posedge clock);
    endtask
    task automatic adc(input logic [7:0] sel, input logic [15:0] v);
        @(posedge clock);
        {adcValid, adcSel, adcValue} <= {1'b1, sel, v};
        @(posedge clock);
        {adcValid, adcValue} <= {1'b0, ~v};
        core(3);
    endtask
    // Reset values and memory correction bit
    task automatic t_reset();
        chk({8'h00, adcSelect}, 16'h0000);
        rd(1'b0, C_ADCSEL, 16'h0000);
        rd(1'b0, C_INFO, 16'h0020);
        @(posedge clock);
        {eccCorrected, bulkReadDone} <= 2'b11;
        @(posedge clock);
        bulkReadDone <= 1'b0;
        core(2);
        rd(1'b0, C_INFO, 16'h0000);
        @(posedge clock);
        eccCorrected <= 1'b0;
        wr(1'b0, C_RESTORE, 16'h0000);
        rd(1'b0, C_INFO, 16'h0020);
    endtask
    // Vendor byte: summary, alert, clearing, paged bit
    task automatic t_vendor();
        @(posedge clock);
        {vendorEvent, gpioExtLow} <= {7'h06, 2'b01};
        @(posedge clock);
        {vendorEvent, gpioExtLow} <= '0;
        core(3);
        chk({14'h0, vendorSummary}, 16'h0003);
        chk({15'h0, alertOe}, 16'h0001);
        rd(1'b0, C_VSTAT, 16'h100d);
        rd(1'b1, C_VSTAT, 16'h100c);
        wr(1'b0, C_VSTAT, 16'h00ff);
        rd(1'b0, C_VSTAT, 16'h1008);
        wr(1'b0, C_LOGERASE, 16'h0000);
        rd(1'b1, C_VSTAT, 16'h0000);
        chk({15'h0, alertOe}, 16'h0000);
    endtask
    // Pin word and common byte, each driven input seen high and low
    task automatic t_pins(input logic [13:0] p, input logic [5:0] q);
        @(posedge clock);
        {coreSupplyOv, coreSupplyUv, adcInvalid, syncDisabled, powerOk, driveEnableLow,
            enablePin, driveFaultLow, faultPin} <= p;
        {busy, calcPending, inTransition, nvmInit, sharedTimebaseTimeout, wpPin} <= q;
        core(4);
        rd(1'b0, C_PINS, {p[13:12], 2'b00, p[11:0]});
        rd(1'b0, C_COMMON, {8'h00, 1'b1, ~q[5:3], q[2], 1'b0, q[1:0]});
    endtask
    // Select byte, reserved value, read-only write, short loop flags
    task automatic t_select();
        wr(1'b0, C_VIN, 16'h1234);
        chk({15'h0, cmlFlags[7]}, 16'h0001);
        wr(1'b0, C_ADCSEL, 16'h0006);
        rd(1'b0, C_ADCSEL, 16'h0006);
        wr(1'b0, C_ADCSEL, 16'h000b);
        rd(1'b0, C_ADCSEL, 16'h0004);
        chk({15'h0, cmlFlags[6]}, 16'h0001);
        wr(1'b0, C_CLRALL, 16'h0000);
        chk({8'h00, cmlFlags}, 16'h0000);
        wr(1'b0, C_ADCSEL, {8'h00, S_SRR});
        adc(S_VOUT0, 16'h0800);
        rd(1'b0, C_SRR, 16'h0001);
        wr(1'b0, C_SRR, 16'h0001);
        rd(1'b0, C_SRR, 16'h0000);
    endtask
    // Output voltage reading and its peak, then peak clear
    task automatic t_peak();
        adc(S_VOUT0, 16'h1234);
        adc(S_VOUT0, 16'h1000);
        rd(1'b0, C_VOUT, 16'h1000);
        rd(1'b0, C_VOPK, 16'h1234);
        rd(1'b1, C_VOPK, 16'h0000);
        wr(1'b0, C_PEAKRST, 16'h0000);
        rd(1'b0, C_VOPK, 16'h0000);
    endtask
    // Temperatures, their peaks and the input current sums
    task automatic t_telem();
        @(posedge clock);
        inputCurrentOffset <= {11'h005, 11'h003};
        adc(S_TEXT0, 16'h0123);
        adc(S_TDIE, 16'h0045);
        rd(1'b0, C_TEXT, 16'hf123);
        rd(1'b0, C_TEPK, 16'hf123);
        rd(1'b0, C_TDIE, 16'hf045);
        rd(1'b0, C_TDPK, 16'hf045);
        rd(1'b0, C_IINCH, 16'he803);
        rd(1'b1, C_IINCH, 16'he805);
        rd(1'b0, C_IIN, 16'hf004);
    endtask
    task automatic results();
        $display("checks %0d, mismatches %0d", tests_run, n_fail);
        if (n_fail == 0 && tests_run > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    // Watchdog well beyond the expected run of roughly ten microseconds
    initial begin
        #400us;
        n_fail++;
        results();
    end
    // Main sequence
    initial begin
        {vendorEvent, gpioExtLow, bulkReadDone, eccCorrected, adcValid, adcSel, adcValue} = '0;
        {coreSupplyOv, coreSupplyUv, adcInvalid, syncDisabled, powerOk, driveEnableLow} = '0;
        {enablePin, driveFaultLow, faultPin, busy, calcPending, inTransition} = '0;
        {nvmInit, sharedTimebaseTimeout, wpPin, freqMant, voutExp} = '0;
        dutyFrac = {10'h100, 10'h200};
        {poutMant, inputCurrentOffset, extTempOffset} = '0;
        {currentGain, extTempGain} = {4{11'h100}};
        currentGainTempco = '0;
        // Two core edges span many fast link edges, so the link reset settles too
        core(2);
        rst_b <= 1'b1;
        core(4);
        t_reset();
        t_vendor();
        t_pins(14'h2a5b, 6'h15);
        t_pins(14'h15a4, 6'h2a);
        t_select();
        t_peak();
        t_telem();
        results();
    end
endmodule
`default_nettype wire
